/* fcs_sequencer.sv */
// Top of the flyback switch cycle sequencer: ramp, timers, OVP hiccup.
// Assumes comparator levels from the analog front end arrive asynchronously.
// Notes on behaviour
// RULE1: Start minimum-period timer when switch turns on.
// RULE2: Minimum period equals ramp rise time.
// RULE3: After it, turn on at valley or catch.
// RULE4: Catch timer starts when ramp falls.
// RULE5: Dimmer detected: hard switching, fixed ramp period.
// RULE6: Valley disable below 1V, enable above 1.2V.
// RULE7: Sample aux 1.84us after switch falls.
// RULE8: Aux above 1.75V flags overvoltage fault.
// RULE9: Fault holds switch off 812ms, then restarts.
// RULE10: During fault discharge comp, loop disabled.
// RULE11: Fault cleared: stop timer, reactivate loop.
// RULE12: Duty from comp level versus triggered ramp.
// RULE13: No drive until comp exceeds 280mV.
// RULE14: Switch off when ramp exceeds comp level.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_sequencer #(
  parameter int RAMP_W    = `FCS_RAMP_W,
  parameter int FAULT_CYC = `FCS_FAULT_CYC
) (
  // Clock and reset (reset from supply undervoltage lockout)
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // Loop level, digitised error amplifier output
  input  wire logic [RAMP_W-1:0] comp_level_in,
  // Comparator levels from analog front end
  input  wire logic              comp_above_min_in,
  input  wire logic              valley_seen_in,
  input  wire logic              dimmer_below_1v_in,
  input  wire logic              dimmer_above_1v2_in,
  input  wire logic              aux_over_threshold_in,
  // Power stage controls
  output logic                   main_switch_out,
  output logic                   comp_discharge_out,
  output logic                   loop_enable_out,
  // Status
  output logic                   valley_mode_out,
  output logic                   ovp_fault_out,
  output logic [RAMP_W-1:0]      ramp_out
);
  localparam logic [RAMP_W-1:0] RAMP_MAX = '1;

  // Synchronisers: first stage feeds only the second
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       cmin_s;
  logic       valley_s;
  logic       dlow_s;
  logic       dhigh_s;
  logic       aux_s;

  fcs_pkg::fcs_state_t state_q;
  logic [RAMP_W-1:0]   ramp_q;       // Ramp value
  logic                valley_en_q;  // Valley switching allowed
  logic                ovp_q;        // Fault latched
  logic                minper_ok_q;  // Minimum period elapsed
  logic [`FCS_FAULT_W-1:0] fault_cnt_q;  // Hiccup countdown
  logic                ramp_tick;    // Ramp step enable
  logic [`FCS_CNT_W-1:0]   rdiv_q;       // Ramp step divider
  logic                turn_on;
  logic                turn_off;
  logic                fault_hit;    // Late aux sample above threshold
  logic                fault_end;    // Last cycle of the hiccup
  logic                ovp_d;        // Next value of the fault latch

  fcs_timer_if minper_if ();
  fcs_timer_if catch_if ();
  fcs_timer_if sample_if ();

  // Two-flop synchroniser for all asynchronous comparator levels
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= {comp_above_min_in, valley_seen_in, dimmer_below_1v_in,
                  dimmer_above_1v2_in, aux_over_threshold_in};
      sync2_q <= sync1_q;
    end
  end
  assign cmin_s   = sync2_q[4];
  assign valley_s = sync2_q[3];
  assign dlow_s   = sync2_q[2];
  assign dhigh_s  = sync2_q[1];
  assign aux_s    = sync2_q[0];

  // Minimum-period timer, equal to the ramp rise time
  fcs_timer #(.W(`FCS_CNT_W), .LEN(`FCS_MIN_PERIOD_CYC)) u_minper (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tif         (minper_if)
  );
  // Catch timer bounding the lowest frequency
  fcs_timer #(.W(`FCS_CNT_W), .LEN(`FCS_CATCH_CYC)) u_catch (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tif         (catch_if)
  );
  // Aux sample delay after switch turn-off
  fcs_timer #(.W(`FCS_CNT_W), .LEN(`FCS_SAMPLE_CYC)) u_sample (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tif         (sample_if)
  );

  assign minper_if.start = turn_on;                                   // [RULE1]
  assign catch_if.start  = (state_q == fcs_pkg::FCS_ON) && turn_off;  // [RULE4]
  assign sample_if.start = (state_q == fcs_pkg::FCS_ON) && turn_off;  // [RULE7]

  // Ramp step divider: one step per cycle here, as the minimum period is shorter than the full ramp
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || turn_on)
      rdiv_q <= '0;
    else if (ramp_tick)
      rdiv_q <= '0;
    else
      rdiv_q <= rdiv_q + `FCS_CNT_W'(1);
  end
  // Steps rounded down; a zero quotient steps every cycle, so the timer ends the ramp near 580, below its top
  assign ramp_tick = (rdiv_q == `FCS_CNT_W'((`FCS_MIN_PERIOD_CYC / (1 << RAMP_W)) - 1)) ||
                     ((`FCS_MIN_PERIOD_CYC / (1 << RAMP_W)) == 0);

  // Ramp rises while switch is on, drops when it turns off
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || turn_off || state_q != fcs_pkg::FCS_ON)
      ramp_q <= '0;
    else if (ramp_tick && ramp_q != RAMP_MAX)
      ramp_q <= ramp_q + RAMP_W'(1);  // [RULE12]
  end

  // Valley enable with hysteresis on the dimmer filter level
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      valley_en_q <= 1'b1;
    else if (dlow_s)
      valley_en_q <= 1'b0;  // [RULE5] [RULE6]
    else if (dhigh_s)
      valley_en_q <= 1'b1;  // [RULE6]
  end

  // Minimum period flag: cleared at turn-on, set on expiry
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || turn_on)
      minper_ok_q <= 1'b0;
    else if (minper_if.done)
      minper_ok_q <= 1'b1;  // [RULE2]
  end

  // Turn-on: min period gone and valley or catch expiry; hard mode ignores valley
  // A restart after a short fault still honours the minimum period; a fault blocks turn-on
  assign turn_on = !fault_hit &&
                   ((state_q == fcs_pkg::FCS_IDLE && cmin_s && !minper_if.busy) ||
                    (state_q == fcs_pkg::FCS_OFF && cmin_s && minper_ok_q &&
                     ((valley_en_q && valley_s) || !catch_if.busy)));  // [RULE3] [RULE5] [RULE13]
  // Turn-off: ramp crosses comp level or rise interval ends
  assign turn_off = (state_q == fcs_pkg::FCS_ON) &&
                    ((ramp_q >= comp_level_in) || minper_if.done);  // [RULE14]

  // Fault is taken in any switching state, so latch and state never disagree
  assign fault_hit = sample_if.done && aux_s;  // [RULE8]
  assign fault_end = (state_q == fcs_pkg::FCS_FAULT) && (fault_cnt_q == `FCS_FAULT_W'(1));
  assign ovp_d     = fault_hit || (ovp_q && !fault_end);

  // OVP fault latch: set on late aux sample, cleared when hiccup ends
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      ovp_q <= 1'b0;
    else if (fault_hit)
      ovp_q <= 1'b1;  // [RULE8]
    else if (fault_end)
      ovp_q <= 1'b0;  // [RULE11]
  end

  // Hiccup countdown; stopped as soon as the fault state is left
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || state_q != fcs_pkg::FCS_FAULT)
      fault_cnt_q <= `FCS_FAULT_W'(FAULT_CYC);
    else if (fault_cnt_q != '0)
      fault_cnt_q <= fault_cnt_q - `FCS_FAULT_W'(1);  // [RULE9]
  end

  // Cycle state machine
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      state_q <= fcs_pkg::FCS_IDLE;
    else
    begin
      unique case (state_q)
        fcs_pkg::FCS_IDLE:
          if (turn_on)
            state_q <= fcs_pkg::FCS_ON;
        fcs_pkg::FCS_ON:
          // A sample landing after an early valley restart still trips the fault
          if (fault_hit)
            state_q <= fcs_pkg::FCS_FAULT;  // [RULE9]
          else if (turn_off)
            state_q <= fcs_pkg::FCS_OFF;
        fcs_pkg::FCS_OFF:
          if (fault_hit)
            state_q <= fcs_pkg::FCS_FAULT;  // [RULE9]
          else if (turn_on)
            state_q <= fcs_pkg::FCS_ON;
        fcs_pkg::FCS_FAULT:
          // Restart from idle so the comp threshold gates drive again
          if (fault_end)
            state_q <= fcs_pkg::FCS_IDLE;  // [RULE9] [RULE11]
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      main_switch_out    <= 1'b0;
      comp_discharge_out <= 1'b0;
      loop_enable_out    <= 1'b0;
      ramp_out           <= '0;
    end
    else
    begin
      main_switch_out    <= (state_q == fcs_pkg::FCS_ON && !turn_off && !fault_hit) || turn_on;  // [RULE14]
      // Follow the fault latch's next value so both edges line up with the flag
      comp_discharge_out <= ovp_d;   // [RULE10]
      loop_enable_out    <= !ovp_d;  // [RULE10] [RULE11]
      ramp_out           <= ramp_q;
    end
  end
  assign valley_mode_out = valley_en_q;
  assign ovp_fault_out   = ovp_q;
endmodule : fcs_sequencer
`default_nettype wire

/* fcs_cfg.svh */
// Timing and field constants for the flyback switch cycle sequencer.
// Assumes a 40 MHz core clock; analog comparisons arrive as digital levels.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_CLK_MHZ            40
`define FCS_MIN_PERIOD_NS      14500
`define FCS_MIN_PERIOD_CYC     ((`FCS_MIN_PERIOD_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_CATCH_NS           4000
`define FCS_CATCH_CYC          ((`FCS_CATCH_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_SAMPLE_NS          1840
`define FCS_SAMPLE_CYC         ((`FCS_SAMPLE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_FAULT_MS           812
`define FCS_FAULT_CYC          (`FCS_FAULT_MS * `FCS_CLK_MHZ * 1000)
`define FCS_RAMP_W             10
`define FCS_CNT_W              16
`define FCS_FAULT_W            25
`endif

/* fcs_pkg.sv */
// Types shared by the sequencer modules.
// No assumptions beyond the configuration header.
package fcs_pkg;
  typedef enum logic [1:0] {
    FCS_IDLE  = 2'b00,  // Waiting for loop to come up
    FCS_ON    = 2'b01,  // Switch conducting, ramp rising
    FCS_OFF   = 2'b10,  // Switch off, waiting for re-arm
    FCS_FAULT = 2'b11   // Overvoltage hiccup
  } fcs_state_t;
endpackage : fcs_pkg

/* fcs_timer_if.sv */
// Carrier between the sequencer and its one-shot timers.
// Assumes a single clock domain.
`timescale 1ns/10ps
`default_nettype none
interface fcs_timer_if;
  logic start;  // Load the timer
  logic busy;   // Timer still running
  logic done;   // One-cycle expiry pulse
  modport ctrl  (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface : fcs_timer_if
`default_nettype wire

/* fcs_timer.sv */
// Parameterised one-shot timer used for the minimum-period, catch and aux sample intervals.
// Assumes start is a one-cycle pulse on core_clk_in.
`timescale 1ns/10ps
`default_nettype none
module fcs_timer #(
  parameter int W   = 16,
  parameter int LEN = 100
) (
  // Clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  // Control carrier
  fcs_timer_if.timer  tif
);
  logic [W-1:0] cnt_q;  // Cycles remaining

  // Countdown; a restart while running reloads the full length
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      cnt_q <= '0;
    else if (tif.start)
      cnt_q <= W'(LEN);
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign tif.busy = (cnt_q != '0);
  assign tif.done = (cnt_q == W'(1));
endmodule : fcs_timer
`default_nettype wire

/* fcs_aux_model.sv */
// Model of the power switch and the auxiliary winding.
// Assumes the sequencer's switch drive and one clock.
`timescale 1ns/10ps
`default_nettype none
module fcs_aux_model (
  // Clock, drive and fault request
  input  wire logic clk_in,
  input  wire logic switch_in,
  input  wire logic ovp_req_in,
  // Winding comparator levels
  output logic      valley_out,
  output logic      over_out
);
  int unsigned off_q;  // Cycles since turn-off
  // Ringing reaches its first valley 20 cycles after turn-off
  always_ff @(posedge clk_in)
  begin
    off_q <= switch_in ? 0 : off_q + 1;
  end
  assign valley_out = !switch_in && off_q >= 20;
  // Winding stays high only during demagnetising, so a fault is one-shot
  assign over_out   = ovp_req_in && !switch_in && off_q < 100;
endmodule : fcs_aux_model
`default_nettype wire

/* fcs_sequencer_props.sv */
// Port checker for the switch cycle sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module fcs_sequencer_props #(
  parameter int FAULT_CYC = 200
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic dimmer_below_1v_in,
  input wire logic dimmer_above_1v2_in,
  input wire logic main_switch_out,
  input wire logic comp_discharge_out,
  input wire logic loop_enable_out,
  input wire logic valley_mode_out,
  input wire logic ovp_fault_out
);
  localparam int MIN_P  = 580;  // Minimum on-to-on period
  localparam int MAX_ON = 581;  // One edge slack for the registered drive
  logic        sw_q;      // Drive one cycle ago
  logic [15:0] gap_q;     // Cycles since turn-on, saturating
  logic [31:0] flt_q;     // Cycles spent in fault
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Helper counters for the long intervals
  always_ff @(posedge core_clk_in)
  begin
    sw_q  <= main_switch_out;
    flt_q <= ovp_fault_out ? flt_q + 32'h1 : 32'h0;
    if (rst_in)
      gap_q <= 16'hffff;
    else if (main_switch_out && !sw_q)
      gap_q <= 16'h1;
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h1;
  end
  fault_sw_off_a: assert property (ovp_fault_out |-> !main_switch_out)
    else $error("Switch on during fault");
  fault_loop_a: assert property (ovp_fault_out |-> comp_discharge_out && !loop_enable_out)
    else $error("Loop active during fault");
  fault_len_a: assert property ($fell(ovp_fault_out) |-> flt_q >= FAULT_CYC - 1 && flt_q <= FAULT_CYC + 1)
    else $error("Fault interval wrong");
  fault_end_a: assert property ($fell(ovp_fault_out) |-> ##[0:2] (loop_enable_out && !comp_discharge_out))
    else $error("Loop not restored");
  max_on_a: assert property ($rose(main_switch_out) |-> ##[1:MAX_ON] !main_switch_out)
    else $error("On time too long");
  min_period_a: assert property (main_switch_out && !sw_q |-> gap_q >= MIN_P)
    else $error("Period below minimum");
  valley_off_a: assert property ($rose(dimmer_below_1v_in) |-> ##[1:4] !valley_mode_out)
    else $error("Valley mode not disabled");
  valley_hold_a: assert property (!valley_mode_out && !dimmer_above_1v2_in && !$past(dimmer_above_1v2_in) &&
    !$past(dimmer_above_1v2_in, 2) && !$past(dimmer_above_1v2_in, 3) |=> !valley_mode_out)
    else $error("Valley mode enabled early");
  cover property ($rose(main_switch_out));
  cover property ($rose(ovp_fault_out));
  cover property ($fell(valley_mode_out));
endmodule : fcs_sequencer_props
bind fcs_sequencer fcs_sequencer_props #(.FAULT_CYC(FAULT_CYC)) fcs_sequencer_props_inst (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .dimmer_below_1v_in(dimmer_below_1v_in),
  .dimmer_above_1v2_in(dimmer_above_1v2_in), .main_switch_out(main_switch_out),
  .comp_discharge_out(comp_discharge_out), .loop_enable_out(loop_enable_out),
  .valley_mode_out(valley_mode_out), .ovp_fault_out(ovp_fault_out));
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the switch cycle sequencer.
// Assumes the winding model and a 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int FLT = 200;  // Shortened fault interval
  typedef struct { logic [9:0] lvl; logic hard; int on; int per; } fcs_row_t;
  // Valley hides the catch timeout in row 1 and ends the wait in row 2 (first valley 20 cycles
  // after turn-off, two synchroniser edges, one drive edge); hard mode shows the timeout in rows 3 and 4
  fcs_row_t rows [5] = '{'{10'h064, 1'b0, 100, 580}, '{10'h1f4, 1'b0, 500, 580},
                         '{10'h3ff, 1'b0, 580, 603},
                         '{10'h1f4, 1'b1, 500, 661}, '{10'h3ff, 1'b1, 580, 740}};
  logic clk = 1'b0, rst = 1'b1, amin = 1'b0, below = 1'b0, above = 1'b1, req = 1'b0;
  logic [9:0] lvl = 10'h064;
  logic [9:0] ramp;
  logic sw, dis, len, vm, ovp, val, over;
  int n_mismatch = 0;
  int n_compared = 0;
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  fcs_sequencer #(.RAMP_W(10), .FAULT_CYC(FLT)) fcs_sequencer_inst (.core_clk_in(clk), .rst_in(rst),
    .comp_level_in(lvl), .comp_above_min_in(amin), .valley_seen_in(val), .dimmer_below_1v_in(below),
    .dimmer_above_1v2_in(above), .aux_over_threshold_in(over), .main_switch_out(sw), .comp_discharge_out(dis),
    .loop_enable_out(len), .valley_mode_out(vm), .ovp_fault_out(ovp), .ramp_out(ramp));
  fcs_aux_model fcs_aux_model_inst (.clk_in(clk), .switch_in(sw), .ovp_req_in(req), .valley_out(val),
    .over_out(over));
  task automatic report(input int got, input int exp);
    n_mismatch++;
    $display("ERROR t=%0t got %h exp %h", $time, got, exp);
  endtask : report
  // Interval compare, three cycles of slack for synchronisers
  task automatic check_t(input int got, input int exp);
    n_compared++;
    if (got < exp - 3 || got > exp + 3) report(got, exp);
  endtask : check_t
  task automatic check_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) report(int'(got), int'(exp));
  endtask : check_b
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // Waits for a turn-on, then times its on span and its period
  task automatic measure(output int on, output int per);
    on = 0;
    per = 0;
    while (sw !== 1'b0 && per < 2000) begin tick(1); per++; end
    while (sw !== 1'b1 && per < 4000) begin tick(1); per++; end
    per = 0;
    while (sw === 1'b1 && on < 2000) begin tick(1); on++; per++; end
    while (sw !== 1'b1 && per < 4000) begin tick(1); per++; end
  endtask : measure
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #750000;
    n_mismatch++;
    results();
  end
  initial
  begin
    int on, per;
    tick(20);
    rst = 1'b0;
    tick(100);
    check_b(len, 1'b1);
    check_b(vm, 1'b1);
    check_b(sw, 1'b0);
    $display("Reset test done");
    amin = 1'b1;
    foreach (rows[i])
    begin
      lvl = rows[i].lvl;
      below = rows[i].hard;
      above = !rows[i].hard;
      measure(on, per);
      measure(on, per);
      check_b(vm, !rows[i].hard);
      check_t(on, rows[i].on);
      check_t(per, rows[i].per);
      $display("Row %0d done", i);
    end
    lvl = 10'h064;
    below = 1'b0;
    above = 1'b1;
    measure(on, per);
    tick(on + 2);
    check_b(ramp === 10'h000, 1'b1);
    measure(on, per);
    // Raise the fault while the switch is on and hold it until the flag sets, so the first late sample is the one timed
    req = 1'b1;
    on = 0;
    while (sw === 1'b1 && on < 2000) begin tick(1); on++; end
    per = 0;
    while (ovp !== 1'b1 && per < 2000) begin tick(1); per++; end
    req = 1'b0;
    check_t(per, 74);
    check_b(dis, 1'b1);
    on = 0;
    while (ovp === 1'b1 && on < 2000) begin tick(1); on++; end
    check_t(on, FLT);
    tick(3);
    check_b(len, 1'b1);
    measure(on, per);
    check_t(on, 100);
    check_b(vm, 1'b1);
    $display("Fault test done");
    results();
  end
endmodule : tb_top
`default_nettype wire
